// ==== proc_ctrl.v ====
// port role and plug orientation control registers with cc steering
// assumes register accesses arrive as one-cycle strobes from the i2c slave
`timescale 1ns/1ns
`include "proc_map.vh"

// Behaviour
// - test mode clear: accepted messages raise the alert path.
// - test mode set: still answer goodcrc, alert is suppressed.
// - orientation 0: vconn onto cc2, monitor cc1 for bmc.
// - orientation 1: vconn onto cc1, monitor cc2 for bmc.
// - auto discharge watches the cc pin chosen by orientation.
// - role register changes only by manager writes after defaults.
// - role register writable from cc discharge power-up state.
// - pullups reach protected pins only with pass switches closed.
// - toggle bit 6 ignores writes, reads zero.
// - current level bits 5:4: default, 1.5a, 3.0a; resets to 10.
// - termination fields: 01 pullup, 11 open; reset 01.
module proc_ctrl (
  input  wire       clk,
  input  wire       reset,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       cc_discharge_state,
  input  wire       pass_switch_closed,
  input  wire       msg_accepted,
  input  wire       vconn_enable,
  input  wire       pd_delivery_enable,
  input  wire       auto_discharge_enable,
  input  wire       cc1_disconnect,
  input  wire       cc2_disconnect,
  output reg        goodcrc_send,
  output reg        rx_alert,
  output reg        compliance_test_mode,
  output reg        plug_orientation,
  output reg        vconn_on_cc1,
  output reg        vconn_on_cc2,
  output reg        bmc_watch_cc1,
  output reg        bmc_watch_cc2,
  output reg        discharge_disconnect,
  output reg  [1:0] pullup_current_level,
  output reg        cc1_pullup_on,
  output reg        cc2_pullup_on
);

  ////////////////////////////////////////////////////////////////////////
  // loop bounds
  localparam NUM_PINS = 2;
  localparam CODE_W   = 2;

  ////////////////////////////////////////////////////////////////////////
  // register state
  reg  [1:0]                 level;
  reg  [1:0]                 cc1_termination_sel;
  reg  [1:0]                 cc2_termination_sel;

  // next values, built in the combinational blocks below
  reg                        next_compliance_test_mode;
  reg                        next_plug_orientation;
  reg  [1:0]                 next_level;
  reg  [1:0]                 next_cc1_termination_sel;
  reg  [1:0]                 next_cc2_termination_sel;
  reg  [7:0]                 next_reg_rdata;

  // per-pin views; index 0 is cc1, index 1 is cc2
  wire [CODE_W*NUM_PINS-1:0] pin_codes;
  wire [NUM_PINS-1:0]        pin_pullup_req;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // only the documented pull-up code drives; reserved codes stay open
  function term_on;
    input [1:0] code;
    begin
      term_on = (code == `PROC_TERM_PULLUP);
    end
  endfunction

  // address match, shared by the write and read paths
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire       ctrl_hit = addr_is(reg_addr, `PROC_PORT_CTRL_ADDR);
  wire       role_hit = addr_is(reg_addr, `PROC_ROLE_CFG_ADDR);
  wire       ctrl_wr  = reg_wr & ctrl_hit;
  // role writes are honoured only while power-up is in cc discharge
  wire       role_wr  = reg_wr & role_hit & cc_discharge_state;

  // read images; unused bits are tied low
  wire [7:0] role_val = {2'h0, level, cc2_termination_sel,
                         cc1_termination_sel};
  wire [7:0] ctrl_val = {6'h00, compliance_test_mode, plug_orientation};

  ////////////////////////////////////////////////////////////////////////
  // port control next state
  always @* begin
    next_compliance_test_mode = compliance_test_mode;
    next_plug_orientation     = plug_orientation;
    if (ctrl_wr) begin
      next_compliance_test_mode = reg_wdata[`PROC_TEST_MODE_BIT];
      next_plug_orientation     = reg_wdata[`PROC_ORIENT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // role next state; only a manager write moves these fields
  always @* begin
    next_level               = level;
    next_cc2_termination_sel = cc2_termination_sel;
    next_cc1_termination_sel = cc1_termination_sel;
    if (role_wr) begin
      next_level               = reg_wdata[`PROC_LEVEL_HI:`PROC_LEVEL_LO];
      next_cc2_termination_sel = reg_wdata[`PROC_CC2_HI:`PROC_CC2_LO];
      next_cc1_termination_sel = reg_wdata[`PROC_CC1_HI:`PROC_CC1_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register update
  always @(posedge clk) begin
    if (reset) begin
      compliance_test_mode <= 1'b0;
      plug_orientation     <= 1'b0;
      level                <= `PROC_LEVEL_RST;
      cc1_termination_sel  <= `PROC_TERM_RST;
      cc2_termination_sel  <= `PROC_TERM_RST;
    end else begin
      compliance_test_mode <= next_compliance_test_mode;
      plug_orientation     <= next_plug_orientation;
      level                <= next_level;
      cc1_termination_sel  <= next_cc1_termination_sel;
      cc2_termination_sel  <= next_cc2_termination_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads zero
  // held between reads so a slow bus front end can pick it up late
  always @* begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      if (ctrl_hit)
        next_reg_rdata = ctrl_val;
      else if (role_hit)
        next_reg_rdata = role_val;
      else
        next_reg_rdata = 8'h00;
    end
  end

  always @(posedge clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_reg_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin pull-up request; the loop keeps both pins decoded alike
  assign pin_codes = {cc2_termination_sel, cc1_termination_sel};

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
      // pullups sit on the low side; open switches hide them
      assign pin_pullup_req[g] = pass_switch_closed &
                                 term_on(pin_codes[g*CODE_W +: CODE_W]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // message path
  always @(posedge clk) begin
    if (reset) begin
      goodcrc_send <= 1'b0;
      rx_alert     <= 1'b0;
    end else begin
      goodcrc_send <= msg_accepted;
      // test mode keeps received messages off the alert path
      rx_alert     <= msg_accepted & ~compliance_test_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // orientation steering
  always @(posedge clk) begin
    if (reset) begin
      vconn_on_cc1  <= 1'b0;
      vconn_on_cc2  <= 1'b0;
      bmc_watch_cc1 <= 1'b0;
      bmc_watch_cc2 <= 1'b0;
    end else begin
      vconn_on_cc2  <= vconn_enable & ~plug_orientation;
      vconn_on_cc1  <= vconn_enable & plug_orientation;
      bmc_watch_cc1 <= pd_delivery_enable & ~plug_orientation;
      bmc_watch_cc2 <= pd_delivery_enable & plug_orientation;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // discharge watch
  always @(posedge clk) begin
    if (reset) begin
      discharge_disconnect <= 1'b0;
    end else begin
      // watch the pin that carries the cc line, not vconn
      discharge_disconnect <= auto_discharge_enable &
        (plug_orientation ? cc2_disconnect : cc1_disconnect);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // role outputs, one cycle behind the register
  always @(posedge clk) begin
    if (reset) begin
      pullup_current_level <= 2'h0;
      cc1_pullup_on        <= 1'b0;
      cc2_pullup_on        <= 1'b0;
    end else begin
      pullup_current_level <= level;
      cc1_pullup_on        <= pin_pullup_req[0];
      cc2_pullup_on        <= pin_pullup_req[1];
    end
  end

endmodule

// ==== proc_map.vh ====
// register map constants for the port role / orientation control block
// assumes an 8-bit register port decoded by the i2c front end outside
`ifndef PROC_MAP_VH
`define PROC_MAP_VH
`define PROC_PORT_CTRL_ADDR   8'h19
`define PROC_ROLE_CFG_ADDR    8'h1a
`define PROC_ORIENT_BIT       0
`define PROC_TEST_MODE_BIT    1
`define PROC_TOGGLE_BIT       6
`define PROC_LEVEL_HI         5
`define PROC_LEVEL_LO         4
`define PROC_CC2_HI           3
`define PROC_CC2_LO           2
`define PROC_CC1_HI           1
`define PROC_CC1_LO           0
`define PROC_LEVEL_RST        2'h2
`define PROC_TERM_RST         2'h1
`define PROC_TERM_PULLUP      2'h1
`define PROC_TERM_OPEN        2'h3
`define PROC_LEVEL_DEFAULT    2'h0
`define PROC_LEVEL_1A5        2'h1
`define PROC_LEVEL_3A0        2'h2
`endif

// ==== proc_assertions.sv ====
// port checks for the role and orientation block
// assumes proc_ctrl as top, one clock, synchronous reset
`timescale 1ns/1ns
module proc_chk (input wire clk, reset, msg_accepted, compliance_test_mode,
  input wire goodcrc_send, rx_alert, plug_orientation, vconn_enable,
  input wire pd_delivery_enable, vconn_on_cc1, vconn_on_cc2, bmc_watch_cc1,
  input wire bmc_watch_cc2, auto_discharge_enable, cc1_disconnect,
  input wire cc2_disconnect, discharge_disconnect, pass_switch_closed,
  input wire cc1_pullup_on, cc2_pullup_on, reg_rd, reg_wr,
  input wire [7:0] reg_addr, reg_rdata,
  input wire [1:0] pullup_current_level);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // level lags the register by a cycle, so two quiet cycles are needed
  sequence s_quiet;
    !$past(reset, 2) && !(reg_wr && reg_addr == 8'h1a) ##1
    !(reg_wr && reg_addr == 8'h1a);
  endsequence
  property p_crc; msg_accepted |=> goodcrc_send; endproperty
  a_crc: assert property (p_crc) else $error("no goodcrc");
  property p_alr;
    msg_accepted && !compliance_test_mode |=> rx_alert;
  endproperty
  a_alr: assert property (p_alr) else $error("no alert");
  property p_o0;
    vconn_enable && !plug_orientation |=> vconn_on_cc2 && !vconn_on_cc1;
  endproperty
  a_o0: assert property (p_o0) else $error("vconn steer");
  property p_o1;
    pd_delivery_enable && plug_orientation |=> bmc_watch_cc2 && !bmc_watch_cc1;
  endproperty
  a_o1: assert property (p_o1) else $error("bmc steer");
  property p_dis; auto_discharge_enable && (plug_orientation ?
    cc2_disconnect : cc1_disconnect) |=> discharge_disconnect; endproperty
  a_dis: assert property (p_dis) else $error("discharge pin");
  property p_pu; !pass_switch_closed |=> !cc1_pullup_on && !cc2_pullup_on;
  endproperty
  a_pu: assert property (p_pu) else $error("pullup leak");
  property p_rd; reg_rd && reg_addr == 8'h1a |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("top bits set");
  property p_hold; s_quiet |=> $stable(pullup_current_level); endproperty
  a_hold: assert property (p_hold) else $error("level moved");
endmodule
bind proc_ctrl proc_chk u_chk (.*);

// ==== proc_cable.sv ====
// cable partner: accepted-message pulses and pin disconnects
// assumes requests change just after a rising edge
`timescale 1ns/1ns
module proc_cable (input wire clk, send, input wire [1:0] unplug,
  output reg msg_accepted, cc1_disconnect, cc2_disconnect);
  initial {msg_accepted, cc2_disconnect, cc1_disconnect} = 3'h0;
  always @(posedge clk)
    {msg_accepted, cc2_disconnect, cc1_disconnect} <= #1 {send, unplug};
endmodule

// ==== tb_top.sv ====
// self-checking bench for the role and orientation block
// assumes proc_ctrl, its checker and the cable model
`timescale 1ns/1ns
module tb_top;
  reg clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, send = 0;
  reg cc_discharge_state = 1, pass_switch_closed = 1, vconn_enable = 1;
  reg pd_delivery_enable = 1, auto_discharge_enable = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0;
  reg [1:0] unplug = 0;
  wire [7:0] reg_rdata;
  wire [1:0] pullup_current_level;
  wire msg_accepted, cc1_disconnect, cc2_disconnect, goodcrc_send, rx_alert;
  wire compliance_test_mode, plug_orientation, vconn_on_cc1, vconn_on_cc2;
  wire bmc_watch_cc1, bmc_watch_cc2, discharge_disconnect;
  wire cc1_pullup_on, cc2_pullup_on;
  integer n_errors = 0, checks_done = 0, i;
  always #2 clk = ~clk;
  proc_ctrl dut (.*);
  proc_cable cable (.*);
  task cmp(input [7:0] g, e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task acc(input w, input [7:0] a, d);
    tick(1);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    tick(1);
    {reg_wr, reg_rd} = 2'h0;
  endtask
  task t_role;
    acc(0, 8'h1a, 0); cmp(reg_rdata, 8'h25);
    acc(1, 8'h1a, 8'hff); acc(0, 8'h1a, 0); cmp(reg_rdata, 8'h3f);
    cmp({cc1_pullup_on, cc2_pullup_on}, 0);
    for (i = 0; i < 3; i = i + 1) begin
      acc(1, 8'h1a, 8'h05 | i << 4); tick(1);
      cmp({pullup_current_level, cc1_pullup_on, cc2_pullup_on}, i * 4 + 3);
    end
    acc(1, 8'h1a, 8'h08); tick(1); cmp({cc1_pullup_on, cc2_pullup_on}, 0);
    pass_switch_closed = 0;
    acc(1, 8'h1a, 8'h05); tick(1); cmp({cc1_pullup_on, cc2_pullup_on}, 0);
    pass_switch_closed = 1;
    cc_discharge_state = 0;
    acc(1, 8'h1a, 8'h00); acc(0, 8'h1a, 0); cmp(reg_rdata, 8'h05);
    cc_discharge_state = 1;
  endtask
  task t_orient;
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, 8'h19, i); tick(1); auto_discharge_enable = 1;
      cmp({vconn_on_cc1, vconn_on_cc2, bmc_watch_cc1, bmc_watch_cc2},
        i ? 9 : 6);
      unplug = i ? 1 : 2; tick(3); cmp(discharge_disconnect, 0);
      unplug = i ? 2 : 1; tick(3); cmp(discharge_disconnect, 1);
      {unplug, auto_discharge_enable} = 0;
    end
  endtask
  task t_msg;
    for (i = 0; i < 2; i = i + 1) begin
      acc(1, 8'h19, i << 1); send = 1; tick(1); send = 0; tick(1);
      cmp({goodcrc_send, rx_alert}, i ? 2 : 3);
      cmp({compliance_test_mode, plug_orientation}, i << 1);
      acc(0, 8'h19, 0); cmp(reg_rdata, i << 1);
    end
    acc(0, 8'h20, 0); cmp(reg_rdata, 0);
    acc(1, 8'h19, 0); cmp(compliance_test_mode, 0);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(20);
    reset = 0;
    t_role; t_orient; t_msg;
    end_of_test;
  end
endmodule
